// *** dpm_regs.vh ***
// Constants of the display power state manager: states, timings, field positions
// Assumes a 25 MHz controller clock and plain Verilog-2005 includers
`ifndef DPM_REGS_VH
`define DPM_REGS_VH
`define DPM_CLK_HZ          25000000
`define DPM_ON_SKEW_MS      64
`define DPM_OFF_SKEW_MS     16
`define DPM_ON_SKEW_CYC     ((`DPM_CLK_HZ / 1000) * `DPM_ON_SKEW_MS)
`define DPM_OFF_SKEW_CYC    ((`DPM_CLK_HZ / 1000) * `DPM_OFF_SKEW_MS)
`define DPM_IDLE_DEF_CYC    32'h0016_e360
`define DPM_ST_ACTIVE       3'h0
`define DPM_ST_STANDBY      3'h1
`define DPM_ST_SUSPEND      3'h2
`define DPM_ST_OFF          3'h3
`define DPM_ST_COVER        3'h4
`define DPM_REQ_NONE        2'h0
`define DPM_REQ_STANDBY     2'h1
`define DPM_REQ_SUSPEND     2'h2
`define DPM_REQ_OFF         2'h3
`define DPM_COVER_BIT       7
`endif

// *** dpm_skew_timer.v ***
// Down counter that reports when a loaded skew interval has run out
// Assumes load and count share the controller clock
module dpm_skew_timer #(
  parameter WIDTH = 24
) (
  input  wire             clk_i,
  input  wire             rst_n_i,
  input  wire             load_i,
  input  wire [WIDTH-1:0] count_i,
  output reg              done_o
);
  reg [WIDTH-1:0] remain;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      remain <= {WIDTH{1'b0}};
      done_o <= 1'b0;
    end else if (load_i) begin
      remain <= count_i;
      done_o <= 1'b0;
    end else if (remain != {WIDTH{1'b0}}) begin
      remain <= remain - {{(WIDTH-1){1'b0}}, 1'b1};
      done_o <= (remain == {{(WIDTH-1){1'b0}}, 1'b1});
    end else begin
      done_o <= 1'b0;
    end
  end
endmodule

// *** dpm_power_manager.v ***
// Display power state manager: power states, sync gating and panel power sequencing
// Assumes host strobes come from logic on clk_i; keyboard and off pins are asynchronous
// Operation
// - Five power states, several triggers
// - Sync gating depends on state
// - Standby entered by time-out or host
// - Standby resumes by host or keyboard
// - Standby stops CRT and DAC, allows access
// - Suspend saves like standby, different syncs
// - Suspend resumes by host or keyboard
// - Off entered by time-out, host, pin
// - Off left only by off pin
// - Off halts cycles, clocks, DAC; slow refresh
// - Off refuses memory and register access
// - Cover bit turns pin off into cover-close
// - Cover-close kills backlight, keeps CRT
// - Three panel power enables driven
// - Power-on skew 64 ms logic then bias
// - Power-off skew 16 ms bias then logic
// - Reverse order, fixed skews
// - Idle timer and triggers detect inactivity
`include "dpm_regs.vh"
module dpm_power_manager #(
  parameter [31:0] ON_SKEW_CYC  = `DPM_ON_SKEW_CYC,
  parameter [31:0] OFF_SKEW_CYC = `DPM_OFF_SKEW_CYC,
  parameter        TW           = 24
) (
  input  wire        clk_i,
  input  wire        rst_n_i,
  input  wire        host_access_i,
  input  wire        host_req_valid_i,
  input  wire [1:0]  host_req_state_i,
  input  wire        host_resume_i,
  input  wire [7:0]  ext_seq_d2_i,
  input  wire [31:0] idle_timeout_i,
  input  wire [1:0]  idle_target_i,
  input  wire        kbd_req_i,
  input  wire        off_pin_i,
  output reg  [2:0]  power_state_o,
  output reg         hsync_en_o,
  output reg         vsync_en_o,
  output reg         crt_cycle_en_o,
  output reg         dac_en_o,
  output reg         synth_en_o,
  output reg         cpu_cycle_en_o,
  output reg         screen_buf_en_o,
  output reg         display_sig_en_o,
  output reg         host_access_allow_o,
  output reg         dram_slow_refresh_o,
  output reg         panel_partial_en_o,
  output reg         panel_logic_power_en_o,
  output reg         panel_bias_en_o,
  output reg         backlight_en_o
);
  localparam [1:0] SQ_IDLE   = 2'h0;
  localparam [1:0] SQ_UP     = 2'h1;
  localparam [1:0] SQ_DOWN   = 2'h2;

  // Two-flop synchronisers; first stage read only by the second
  reg        kbd_s1;
  reg        kbd_s2;
  reg        kbd_s3;
  reg        off_s1;
  reg        off_s2;
  reg        off_s3;
  wire       kbd_rise;
  wire       off_rise;

  reg  [2:0] state;
  reg  [2:0] next_state;
  reg [31:0] idle_cnt;
  wire       idle_expired;
  reg  [1:0] seq;
  reg        tmr_load;
  reg [TW-1:0] tmr_count;
  wire       tmr_done;
  wire       panel_on_target;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      kbd_s1 <= 1'b0;
      kbd_s2 <= 1'b0;
      kbd_s3 <= 1'b0;
      off_s1 <= 1'b0;
      off_s2 <= 1'b0;
      off_s3 <= 1'b0;
    end else begin
      kbd_s1 <= kbd_req_i;
      kbd_s2 <= kbd_s1;
      kbd_s3 <= kbd_s2;
      off_s1 <= off_pin_i;
      off_s2 <= off_s1;
      off_s3 <= off_s2;
    end
  end

  assign kbd_rise = kbd_s2 & ~kbd_s3;
  assign off_rise = off_s2 & ~off_s3;

  // Idle counter only runs in active; zero time-out disables it
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      idle_cnt <= 32'h0000_0000;
    end else if (state != `DPM_ST_ACTIVE || host_access_i || kbd_rise) begin
      idle_cnt <= 32'h0000_0000;
    end else if (idle_timeout_i != 32'h0000_0000 && idle_cnt != idle_timeout_i) begin
      idle_cnt <= idle_cnt + 32'h0000_0001;
    end
  end

  assign idle_expired = (state == `DPM_ST_ACTIVE) && (idle_timeout_i != 32'h0000_0000) &&
                        (idle_cnt == idle_timeout_i) && !host_access_i && !kbd_rise;

  // Transitions; host requests win over a same-cycle time-out
  always @* begin
    next_state = state;
    case (state)
      `DPM_ST_ACTIVE: begin
        if (off_rise) begin
          if (ext_seq_d2_i[`DPM_COVER_BIT]) begin
            next_state = `DPM_ST_COVER;
          end else begin
            next_state = `DPM_ST_OFF;
          end
        end else if (host_req_valid_i && host_req_state_i == `DPM_REQ_STANDBY) begin
          next_state = `DPM_ST_STANDBY;
        end else if (host_req_valid_i && host_req_state_i == `DPM_REQ_SUSPEND) begin
          next_state = `DPM_ST_SUSPEND;
        end else if (host_req_valid_i && host_req_state_i == `DPM_REQ_OFF) begin
          next_state = `DPM_ST_OFF;
        end else if (idle_expired) begin
          case (idle_target_i)
            `DPM_REQ_SUSPEND: next_state = `DPM_ST_SUSPEND;
            `DPM_REQ_OFF:     next_state = `DPM_ST_OFF;
            default:          next_state = `DPM_ST_STANDBY;
          endcase
        end
      end
      `DPM_ST_STANDBY: begin
        if (host_resume_i || kbd_rise) begin
          next_state = `DPM_ST_ACTIVE;
        end else if (off_rise) begin
          next_state = ext_seq_d2_i[`DPM_COVER_BIT] ? `DPM_ST_COVER : `DPM_ST_OFF;
        end else if (host_req_valid_i && host_req_state_i == `DPM_REQ_SUSPEND) begin
          next_state = `DPM_ST_SUSPEND;
        end else if (host_req_valid_i && host_req_state_i == `DPM_REQ_OFF) begin
          next_state = `DPM_ST_OFF;
        end
      end
      `DPM_ST_SUSPEND: begin
        if (host_resume_i || kbd_rise) begin
          next_state = `DPM_ST_ACTIVE;
        end else if (off_rise) begin
          next_state = ext_seq_d2_i[`DPM_COVER_BIT] ? `DPM_ST_COVER : `DPM_ST_OFF;
        end else if (host_req_valid_i && host_req_state_i == `DPM_REQ_OFF) begin
          next_state = `DPM_ST_OFF;
        end
      end
      `DPM_ST_OFF: begin
        // Host is locked out here, so only the pin can wake the device
        if (off_rise) begin
          next_state = `DPM_ST_ACTIVE;
        end
      end
      `DPM_ST_COVER: begin
        if (off_rise) begin
          next_state = `DPM_ST_ACTIVE;
        end
      end
      default: next_state = `DPM_ST_ACTIVE;
    endcase
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= `DPM_ST_ACTIVE;
    end else begin
      state <= next_state;
    end
  end

  // Panel is powered only in active; a reversal during power-up restarts from the current enables, power-down always runs to its end
  assign panel_on_target = (next_state == `DPM_ST_ACTIVE);

  dpm_skew_timer #(
    .WIDTH (TW)
  ) u_skew (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .load_i  (tmr_load),
    .count_i (tmr_count),
    .done_o  (tmr_done)
  );

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      seq                    <= SQ_IDLE;
      tmr_load               <= 1'b0;
      tmr_count              <= {TW{1'b0}};
      panel_logic_power_en_o <= 1'b0;
      panel_bias_en_o        <= 1'b0;
      backlight_en_o         <= 1'b0;
    end else begin
      tmr_load <= 1'b0;
      case (seq)
        SQ_IDLE: begin
          if (panel_on_target && !panel_bias_en_o) begin
            panel_logic_power_en_o <= 1'b1;
            tmr_count              <= ON_SKEW_CYC[TW-1:0];
            tmr_load               <= 1'b1;
            seq                    <= SQ_UP;
          end else if (!panel_on_target && panel_logic_power_en_o) begin
            backlight_en_o  <= 1'b0;
            panel_bias_en_o <= 1'b0;
            tmr_count       <= OFF_SKEW_CYC[TW-1:0];
            tmr_load        <= 1'b1;
            seq             <= SQ_DOWN;
          end
        end
        SQ_UP: begin
          if (!panel_on_target) begin
            seq <= SQ_IDLE;
          end else if (tmr_done) begin
            panel_bias_en_o <= 1'b1;
            backlight_en_o  <= 1'b1;
            seq             <= SQ_IDLE;
          end
        end
        SQ_DOWN: begin
          if (tmr_done) begin
            panel_logic_power_en_o <= 1'b0;
            seq                    <= SQ_IDLE;
          end
        end
        default: seq <= SQ_IDLE;
      endcase
    end
  end

  // Per-state gating registered from the state itself
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      power_state_o       <= `DPM_ST_ACTIVE;
      hsync_en_o          <= 1'b1;
      vsync_en_o          <= 1'b1;
      crt_cycle_en_o      <= 1'b1;
      dac_en_o            <= 1'b1;
      synth_en_o          <= 1'b1;
      cpu_cycle_en_o      <= 1'b1;
      screen_buf_en_o     <= 1'b1;
      display_sig_en_o    <= 1'b1;
      host_access_allow_o <= 1'b1;
      dram_slow_refresh_o <= 1'b0;
      panel_partial_en_o  <= 1'b1;
    end else begin
      power_state_o       <= state;
      hsync_en_o          <= (state == `DPM_ST_ACTIVE) || (state == `DPM_ST_SUSPEND) ||
                             (state == `DPM_ST_COVER);
      vsync_en_o          <= (state == `DPM_ST_ACTIVE) || (state == `DPM_ST_STANDBY) ||
                             (state == `DPM_ST_COVER);
      crt_cycle_en_o      <= (state == `DPM_ST_ACTIVE) || (state == `DPM_ST_COVER);
      dac_en_o            <= (state == `DPM_ST_ACTIVE) || (state == `DPM_ST_COVER);
      synth_en_o          <= (state != `DPM_ST_OFF);
      cpu_cycle_en_o      <= (state != `DPM_ST_OFF);
      screen_buf_en_o     <= (state != `DPM_ST_OFF);
      display_sig_en_o    <= (state != `DPM_ST_OFF);
      host_access_allow_o <= (state != `DPM_ST_OFF);
      dram_slow_refresh_o <= (state == `DPM_ST_OFF);
      panel_partial_en_o  <= (state == `DPM_ST_ACTIVE);
    end
  end
endmodule

// *** dpm_power_chk_sv_chk.sv ***
// Checker for the display power state manager: state gating and panel skews
// Assumes a bind to dpm_power_manager with the short skew parameters of the bench
module dpm_power_chk #(
  parameter [31:0] ON_SKEW_CYC  = 20,
  parameter [31:0] OFF_SKEW_CYC = 8
) (
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  input wire logic       host_req_valid_i,
  input wire logic [1:0] host_req_state_i,
  input wire logic       kbd_req_i,
  input wire logic [2:0] power_state_o,
  input wire logic       hsync_en_o,
  input wire logic       vsync_en_o,
  input wire logic       crt_cycle_en_o,
  input wire logic       dac_en_o,
  input wire logic       synth_en_o,
  input wire logic       cpu_cycle_en_o,
  input wire logic       host_access_allow_o,
  input wire logic       dram_slow_refresh_o,
  input wire logic       panel_partial_en_o,
  input wire logic       panel_logic_power_en_o,
  input wire logic       panel_bias_en_o,
  input wire logic       backlight_en_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [31:0] lo_cnt;
  logic [31:0] hi_cnt;
  // Cycles the bias has been off and the logic supply on
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lo_cnt <= '0;
      hi_cnt <= '0;
    end else begin
      lo_cnt <= panel_bias_en_o ? '0 : lo_cnt + 1;
      hi_cnt <= panel_logic_power_en_o ? hi_cnt + 1 : '0;
    end
  end
  sequence s_host_stby;
    host_req_valid_i && host_req_state_i == 2'h1 && power_state_o == 3'h0;
  endsequence
  sequence s_kbd_wake;
    $rose(kbd_req_i) && power_state_o == 3'h1;
  endsequence
  chk_active_gating: assert property (power_state_o == 3'h0 |-> hsync_en_o && vsync_en_o && crt_cycle_en_o && dac_en_o && synth_en_o && cpu_cycle_en_o && host_access_allow_o && !dram_slow_refresh_o)
    else $error("active gating wrong");
  chk_standby_sync: assert property (power_state_o == 3'h1 |-> !hsync_en_o && vsync_en_o && !crt_cycle_en_o && !dac_en_o && host_access_allow_o)
    else $error("standby gating wrong");
  chk_suspend_sync: assert property (power_state_o == 3'h2 |-> hsync_en_o && !vsync_en_o && !crt_cycle_en_o && !dac_en_o)
    else $error("suspend gating wrong");
  chk_off_gating: assert property (power_state_o == 3'h3 |-> !(hsync_en_o | vsync_en_o | synth_en_o | cpu_cycle_en_o | host_access_allow_o) && dram_slow_refresh_o)
    else $error("off gating wrong");
  chk_cover_gating: assert property (power_state_o == 3'h4 |-> hsync_en_o && vsync_en_o && crt_cycle_en_o && !panel_partial_en_o && !backlight_en_o)
    else $error("cover gating wrong");
  chk_on_skew: assert property ($rose(panel_bias_en_o) |-> hi_cnt >= ON_SKEW_CYC - 1 && hi_cnt <= ON_SKEW_CYC + 4)
    else $error("power-on skew wrong");
  chk_off_skew: assert property ($fell(panel_logic_power_en_o) |-> lo_cnt >= OFF_SKEW_CYC - 1)
    else $error("power-off skew short");
  chk_enable_order: assert property (panel_bias_en_o |-> panel_logic_power_en_o)
    else $error("bias without logic supply");
  chk_host_standby: assert property (s_host_stby |-> ##2 power_state_o == 3'h1)
    else $error("host standby not taken");
  chk_kbd_wake: assert property (s_kbd_wake |-> ##[2:7] power_state_o == 3'h0)
    else $error("keyboard wake missing");
endmodule
bind dpm_power_manager dpm_power_chk #(.ON_SKEW_CYC(ON_SKEW_CYC), .OFF_SKEW_CYC(OFF_SKEW_CYC)) u_chk (.*);

// *** dpm_panel_model.sv ***
// Panel supplies and monitor on the far side of the power enables and syncs
// Assumes the enables are levels sampled on the controller clock
module dpm_panel_model (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       panel_logic_power_en_o,
  input  wire logic       panel_bias_en_o,
  input  wire logic       backlight_en_o,
  input  wire logic       hsync_en_o,
  input  wire logic       vsync_en_o,
  output logic            panel_lit_o,
  output logic            panel_fault_o,
  output logic [1:0]      mon_mode_o
);
  assign mon_mode_o  = {~hsync_en_o, ~vsync_en_o};
  assign panel_lit_o = panel_logic_power_en_o & panel_bias_en_o & backlight_en_o;
  // Bias without logic supply can damage a panel, so it is latched
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) panel_fault_o <= 1'b0;
    else if (panel_bias_en_o && !panel_logic_power_en_o) panel_fault_o <= 1'b1;
  end
endmodule

// *** dpm_power_manager_test.sv ***
// Self-checking bench for the display power state manager
// Assumes short skew parameters so each panel sequence lasts under two dozen cycles
module dpm_power_manager_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int ON = 20;
  localparam int OFF = 8;
  logic        clk_i, rst_n_i, host_access_i, host_req_valid_i, host_resume_i;
  logic        kbd_req_i, off_pin_i;
  logic [1:0]  host_req_state_i, idle_target_i;
  logic [7:0]  ext_seq_d2_i;
  logic [31:0] idle_timeout_i;
  wire  [2:0]  power_state_o;
  wire         hsync_en_o, vsync_en_o, crt_cycle_en_o, dac_en_o, synth_en_o, cpu_cycle_en_o;
  wire         screen_buf_en_o, display_sig_en_o, host_access_allow_o, dram_slow_refresh_o;
  wire         panel_partial_en_o, panel_logic_power_en_o, panel_bias_en_o, backlight_en_o;
  wire         panel_lit_o, panel_fault_o;
  wire  [1:0]  mon_mode_o;
  int          err_count, n_checks, seed, i, j, k;
  logic [2:0]  exp_q[$];
  logic [2:0]  last_st;
  dpm_power_manager #(.ON_SKEW_CYC(ON), .OFF_SKEW_CYC(OFF)) uut (.*);
  dpm_panel_model u_panel (.*);
  task automatic check(input logic [2:0] seen, input logic [2:0] want);
    n_checks++;
    if (seen !== want) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Kind 0 host request, 1 host resume, 2 keyboard, 3 off pin; state 7 means refused
  task automatic step(input int kind, input logic [1:0] s, input logic [2:0] st);
    if (st != 3'h7) exp_q.push_back(st);
    host_req_valid_i <= (kind == 0);
    host_req_state_i <= s;
    host_resume_i <= (kind == 1);
    kbd_req_i <= (kind == 2);
    off_pin_i <= (kind == 3);
    tick(1);
    host_req_valid_i <= 1'b0;
    host_resume_i <= 1'b0;
    tick(4);
    kbd_req_i <= 1'b0;
    off_pin_i <= 1'b0;
    k = 0;
    while (st != 3'h7 && power_state_o !== st && k < 200) begin
      tick(1);
      k++;
    end
    tick(ON + OFF + 10);
  endtask
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // Every state change must match the oldest noted expectation
  always @(posedge clk_i) begin
    if (rst_n_i && power_state_o !== last_st) begin
      if (exp_q.size() == 0) check(power_state_o, 3'h7);
      else check(power_state_o, exp_q.pop_front());
      check({1'b0, mon_mode_o}, power_state_o == 3'h1 ? 3'h2 : power_state_o == 3'h2 ? 3'h1 : power_state_o == 3'h3 ? 3'h3 : 3'h0);
    end
    last_st <= power_state_o;
  end
  initial begin
    tick(20000);
    err_count++;
    close_out();
  end
  initial begin
    seed = 32'hec97;
    {rst_n_i, host_access_i, host_req_valid_i, host_resume_i, kbd_req_i, off_pin_i} = '0;
    {host_req_state_i, idle_target_i, ext_seq_d2_i, idle_timeout_i} = '0;
    tick(20);
    rst_n_i <= 1'b1;
    tick(ON + 10);
    check({2'b0, panel_lit_o}, 3'h1);
    for (i = 1; i < 3; i++)
      for (j = 1; j < 3; j++) begin
        step(0, i[1:0], i[2:0]);
        step(j, 2'h0, 3'h0);
      end
    step(0, 2'h1, 3'h1);
    step(0, 2'h2, 3'h2);
    step(0, 2'h3, 3'h3);
    for (i = 0; i < 3; i++) step(i, 2'h1, 3'h7);
    step(3, 2'h0, 3'h0);
    $display("Host and keyboard test done");
    ext_seq_d2_i <= $random(seed) & 8'h7f;
    step(3, 2'h0, 3'h3);
    step(3, 2'h0, 3'h0);
    ext_seq_d2_i <= $random(seed) | 8'h80;
    step(3, 2'h0, 3'h4);
    step(3, 2'h0, 3'h0);
    $display("Off pin test done");
    for (i = 1; i < 4; i++) begin
      idle_target_i <= i[1:0];
      idle_timeout_i <= 32'd60;
      tick(40);
      host_access_i <= 1'b1;
      tick(1);
      host_access_i <= 1'b0;
      exp_q.push_back(i[2:0]);
      k = 0;
      while (power_state_o !== i[2:0] && k < 300) begin
        tick(1);
        k++;
      end
      check({2'b0, k > 56 && k < 300}, 3'h1);
      idle_timeout_i <= '0;
      tick(ON + OFF + 10);
      step(i == 3 ? 3 : 1, 2'h0, 3'h0);
    end
    $display("Idle time-out test done");
    check({2'b0, panel_fault_o}, 3'h0);
    close_out();
  end
endmodule
